// ==== pkg/sun_angle_regs.vh ====
// constants for the sun-angle serial readout
`ifndef SUN_ANGLE_REGS_VH
`define SUN_ANGLE_REGS_VH

// -------------------------------------------------------------
// word layout
// -------------------------------------------------------------
`define ANGLE_BITS            7
`define WORD_BITS             8
`define MARKER_POS            7
`define MARKER_RESET_VAL      1'b1
`define DATA_RESET_VAL        7'h00

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define CLK_PERIOD_NS         10
`define CHOP_RATE_HZ          4000
`define CHOP_HALF_CYCLES      ((1000000000 / `CHOP_RATE_HZ) / (2 * `CLK_PERIOD_NS))
`define SAMPLE_TIME_US        500
`define SAMPLE_CYCLES         ((`SAMPLE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define HOLD_MIN_MS           50
`define HOLD_MAX_MS           100
`define HOLD_CYCLES           ((`HOLD_MIN_MS * 1000000) / `CLK_PERIOD_NS)
`define SHIFT_DIV_CYCLES      1000
`define TRIG_STEP_COUNT       4

`endif

// ==== src/chop_trigger.v ====
// chopped, stepped trigger detector for the reference-plane photocell
`timescale 1ns/1ps
`include "sun_angle_regs.vh"
module chop_trigger
#(
	parameter HALF_CYCLES = `CHOP_HALF_CYCLES,
	parameter STEPS       = `TRIG_STEP_COUNT
)
(
	input  wire core_clk_i,
	input  wire reset_n_i,
	input  wire clk_en_i,
	input  wire eye_lit_i,
	output reg  fire_o
);
	// ---------------------------------------------------------
	// chopper clock and step integrator
	// ---------------------------------------------------------
	reg [15:0] div_q;
	reg        tick_q;
	reg [3:0]  level_q;
	reg        above_q;

	// 8 kc tick, one per 4 kc chop half cycle; integrator only moves on ticks so the threshold
	// is crossed at a discrete step, not an arbitrary point
	always @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			div_q   <= 16'h0000;
			tick_q  <= 1'b0;
			level_q <= 4'h0;
			above_q <= 1'b0;
			fire_o  <= 1'b0;
		end
		else if (clk_en_i)
		begin
			tick_q <= 1'b0;
			fire_o <= 1'b0;
			if (div_q == HALF_CYCLES[15:0] - 16'h0001)
			begin
				div_q  <= 16'h0000;
				tick_q <= 1'b1;
			end
			else
				div_q <= div_q + 16'h0001;
			if (tick_q)
			begin
				if (eye_lit_i && level_q != STEPS[3:0])
					level_q <= level_q + 4'h1;
				else if (!eye_lit_i && level_q != 4'h0)
					level_q <= level_q - 4'h1;
				if (level_q == STEPS[3:0])
					above_q <= 1'b1;
				else if (level_q == 4'h0)
					above_q <= 1'b0;
			end
			// falling edge of detector output starts the sample
			if (tick_q && above_q && level_q == 4'h0)
				fire_o <= 1'b1;
		end
	end
endmodule

// ==== src/two_entry_buf.v ====
// two-entry valid/ready buffer for serial bits
`timescale 1ns/1ps
module two_entry_buf
#(
	parameter WIDTH = 1
)
(
	input  wire             core_clk_i,
	input  wire             reset_n_i,
	input  wire             clk_en_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output reg  [WIDTH-1:0] out_data_o
);
	// ---------------------------------------------------------
	// storage
	// ---------------------------------------------------------
	reg [WIDTH-1:0] mem_q [0:1];
	reg             wr_q;
	reg             rd_q;
	reg [1:0]       cnt_q;
	wire            push;
	wire            pop;

	// handshakes
	assign in_ready_o  = (cnt_q != 2'd2);
	assign out_valid_o = (cnt_q != 2'd0);
	assign push        = in_valid_i && in_ready_o && clk_en_i;
	assign pop         = out_valid_o && out_ready_i && clk_en_i;

	// pointers and count
	always @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'd0;
		end
		else
		begin
			if (push)
				wr_q <= ~wr_q;
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// array write, no reset needed for data
	always @(posedge core_clk_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
	end

	// head word held in a flop
	always @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			out_data_o <= {WIDTH{1'b0}};
		else if (clk_en_i)
		begin
			if (cnt_q == 2'd0 || (pop && cnt_q == 2'd1))
				out_data_o <= in_data_i;
			else if (pop)
				out_data_o <= mem_q[~rd_q];
		end
	end
endmodule

// ==== src/sun_angle_gray_serial_readout.v ====
// sun-angle gray-coded serial readout top
//
// Operation
// - The angle is a seven-bit gray value, one degree per step over 128 degrees.
// - Neighbouring angle codes differ in a single bit.
// - The threshold stages are chained as a shift register whose last stage is the serial out.
// - Seven thresholded bits load the first seven of eight register stages.
// - A readout starts only after the reference-plane trigger cell has seen the sun and gone dark again.
// - The trigger path is chopped at 4 kc and stepped once per chop half cycle (8 kc) so it fires at a discrete step.
// - The trigger falling edge starts a 500 us sample pulse that gates bits in.
// - During sampling a stage sets to one when its level is above midpoint, else stays zero.
// - The shift oscillator runs while any stage holds one.
// - Reset puts one in the end-of-word stage; shifting stops once it has left.
// - After power-up all stages are held inactive 50 to 100 ms, then released for good.
`timescale 1ns/1ps
`include "sun_angle_regs.vh"
module sun_angle_gray_serial_readout
#(
	parameter HOLD_CYCLES   = `HOLD_CYCLES,
	parameter SAMPLE_CYCLES = `SAMPLE_CYCLES,
	parameter SHIFT_DIV     = `SHIFT_DIV_CYCLES,
	parameter CHOP_HALF     = `CHOP_HALF_CYCLES,
	parameter MSB_FIRST     = 1
)
(
	input  wire                    core_clk_i,
	input  wire                    reset_n_i,
	input  wire                    clk_en_i,
	input  wire                    trig_eye_i,
	input  wire [`ANGLE_BITS-1:0]  angle_above_i,
	output wire                    ser_valid_o,
	input  wire                    ser_ready_i,
	output wire                    ser_data_o,
	output reg                     ser_last_o,
	output reg                     busy_o,
	output reg                     hold_o
);
	// ---------------------------------------------------------
	// states
	// ---------------------------------------------------------
	localparam ST_HOLD   = 2'd0;
	localparam ST_IDLE   = 2'd1;
	localparam ST_SAMPLE = 2'd2;
	localparam ST_SHIFT  = 2'd3;

	// ---------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------
	reg                   eye_s1_q;
	reg                   eye_s2_q;
	reg [`ANGLE_BITS-1:0] ang_s1_q;
	reg [`ANGLE_BITS-1:0] ang_s2_q;

	// pins come from analog comparators, so two flops each
	always @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			eye_s1_q <= 1'b0;
			eye_s2_q <= 1'b0;
			ang_s1_q <= `DATA_RESET_VAL;
			ang_s2_q <= `DATA_RESET_VAL;
		end
		else if (clk_en_i)
		begin
			eye_s1_q <= trig_eye_i;
			eye_s2_q <= eye_s1_q;
			ang_s1_q <= angle_above_i;
			ang_s2_q <= ang_s1_q;
		end
	end

	// ---------------------------------------------------------
	// trigger detector
	// ---------------------------------------------------------
	wire fire;

	chop_trigger #(
		.HALF_CYCLES (CHOP_HALF),
		.STEPS       (`TRIG_STEP_COUNT)
	) u_trig (
		.core_clk_i  (core_clk_i),
		.reset_n_i   (reset_n_i),
		.clk_en_i    (clk_en_i),
		.eye_lit_i   (eye_s2_q),
		.fire_o      (fire)
	);

	// ---------------------------------------------------------
	// output buffer
	// ---------------------------------------------------------
	wire buf_ready;
	reg  bit_valid;
	reg  bit_data;

	two_entry_buf #(
		.WIDTH       (1)
	) u_buf (
		.core_clk_i  (core_clk_i),
		.reset_n_i   (reset_n_i),
		.clk_en_i    (clk_en_i),
		.in_valid_i  (bit_valid),
		.in_ready_o  (buf_ready),
		.in_data_i   (bit_data),
		.out_valid_o (ser_valid_o),
		.out_ready_i (ser_ready_i),
		.out_data_o  (ser_data_o)
	);

	// ---------------------------------------------------------
	// shift register and sequencing
	// ---------------------------------------------------------
	// each stage is kept as its zero-side level: 0 means the stage is
	// set, 1 means it is clear. the power-on hold and the shift fill
	// both leave stages clear, so an all-ones register is empty and
	// the zero-side or below is exactly the oscillator enable.
	reg [1:0]             state_q;
	reg [31:0]            cnt_q;
	reg [`WORD_BITS-1:0]  sr_q;
	wire                  any_zero;
	wire                  div_done;
	wire                  osc_tick;
	wire [`WORD_BITS-1:0] sr_next;

	// set-side view of a freshly sampled word: marker on top, then
	// the gray bits exactly as the comparators report them
	// gray bits pass unchanged, one degree moves one bit
	function [`WORD_BITS-1:0] load_word;
		input [`ANGLE_BITS-1:0] above;
		begin
			load_word = {`MARKER_RESET_VAL, above};
		end
	endfunction

	// serial tap: the end stage of the chain, turned back to set side
	function out_bit;
		input [`WORD_BITS-1:0] w;
		begin
			if (MSB_FIRST != 0)
				out_bit = ~w[`ANGLE_BITS-1];
			else
				out_bit = ~w[0];
		end
	endfunction

	// one shift step; a clear stage (1) fills in behind the marker
	// msb first: data climbs toward bit 6, marker drops into bit 0
	// lsb first: whole word walks down, marker reaches bit 0 last
	function [`WORD_BITS-1:0] shift_word;
		input [`WORD_BITS-1:0] w;
		begin
			if (MSB_FIRST != 0)
				shift_word = {1'b1, w[`ANGLE_BITS-2:0], w[`WORD_BITS-1]};
			else
				shift_word = {1'b1, w[`WORD_BITS-1:1]};
		end
	endfunction

	// ---------------------------------------------------------
	// shift oscillator
	// ---------------------------------------------------------
	// zero-side or: oscillator enabled while any stage is set
	assign any_zero = ~&sr_q;
	assign div_done = (cnt_q == SHIFT_DIV - 1);
	// a stall freezes the oscillator so no bit is lost; the pending
	// push must land first, else a fast rate could overrun the buffer
	assign osc_tick = any_zero && div_done && buf_ready && !bit_valid;
	assign sr_next  = shift_word(sr_q);

	// ---------------------------------------------------------
	// main sequencer
	// ---------------------------------------------------------
	// hold -> idle once; idle -> sample on fire; sample -> shift after
	// the sample window; shift -> idle when the marker has left.
	// limitation: the sample window is a fixed count, not a one-shot
	// retriggered by the detector, so a second fire inside it is lost.

	// main sequencer
	always @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q    <= ST_HOLD;
			cnt_q      <= 32'h00000000;
			sr_q       <= {`WORD_BITS{1'b1}};
			bit_valid  <= 1'b0;
			bit_data   <= 1'b0;
			ser_last_o <= 1'b0;
			busy_o     <= 1'b0;
			hold_o     <= 1'b1;
		end
		else if (clk_en_i)
		begin
			bit_valid <= 1'b0;
			case (state_q)
			ST_HOLD:
			begin
				// stages forced inactive until the hold expires
				sr_q <= {`WORD_BITS{1'b1}};
				if (cnt_q == HOLD_CYCLES - 1)
				begin
					cnt_q   <= 32'h00000000;
					hold_o  <= 1'b0;
					state_q <= ST_IDLE;
				end
				else
					cnt_q <= cnt_q + 32'h00000001;
			end
			ST_IDLE:
			begin
				busy_o <= 1'b0;
				if (fire)
				begin
					// reset: data stages clear, marker stage set
					sr_q    <= {~`MARKER_RESET_VAL, ~`DATA_RESET_VAL};
					cnt_q   <= 32'h00000000;
					busy_o  <= 1'b1;
					state_q <= ST_SAMPLE;
				end
			end
			ST_SAMPLE:
			begin
				// only sets are gated in; below-midpoint stays zero
				sr_q <= sr_q & ~load_word(ang_s2_q);
				if (cnt_q == SAMPLE_CYCLES - 1)
				begin
					cnt_q   <= 32'h00000000;
					state_q <= ST_SHIFT;
				end
				else
					cnt_q <= cnt_q + 32'h00000001;
			end
			ST_SHIFT:
			begin
				// fire is not looked at here until the marker is gone
				if (!any_zero)
				begin
					// register empty: oscillator stopped, readout over
					busy_o     <= 1'b0;
					ser_last_o <= 1'b0;
					state_q    <= ST_IDLE;
				end
				else if (osc_tick)
				begin
					cnt_q      <= 32'h00000000;
					bit_valid  <= 1'b1;
					bit_data   <= out_bit(sr_q);
					// marker walks toward the tap; clear stages fill behind
					sr_q       <= sr_next;
					// the shift that empties the register carries the marker
					ser_last_o <= &sr_next;
				end
				else if (!div_done)
					cnt_q <= cnt_q + 32'h00000001;
			end
			default:
				state_q <= ST_HOLD;
			endcase
		end
	end
endmodule

// ==== tb/sun_angle_chk.sv ====
// assertions on the sun-angle readout top ports
`timescale 1ns/1ps
`include "sun_angle_regs.vh"
module sun_angle_chk
#(
	parameter HOLD_CYCLES = 20
)
(
	input wire                   core_clk_i,
	input wire                   reset_n_i,
	input wire                   clk_en_i,
	input wire                   trig_eye_i,
	input wire [`ANGLE_BITS-1:0] angle_above_i,
	input wire                   ser_valid_o,
	input wire                   ser_ready_i,
	input wire                   ser_data_o,
	input wire                   ser_last_o,
	input wire                   busy_o,
	input wire                   hold_o
);
	int   hold_q;
	int   pops_q;
	logic busy_q;
	// hold length and bits popped per readout
	always @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			hold_q <= 0;
			pops_q <= 0;
			busy_q <= 1'b0;
		end
		else
		begin
			busy_q <= busy_o;
			if (hold_o)
				hold_q <= hold_q + 1;
			if (busy_o && !busy_q)
				pops_q <= 0;
			else if (ser_valid_o && ser_ready_i)
				pops_q <= pops_q + 1;
		end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	hold_quiet_a: assert property (hold_o |-> !busy_o && !ser_valid_o)
		else $error("activity during hold");
	hold_once_a: assert property (!hold_o |=> !hold_o)
		else $error("hold came back");
	hold_len_a: assert property ($fell(hold_o) |-> hold_q >= HOLD_CYCLES - 2 && hold_q <= HOLD_CYCLES + 2)
		else $error("hold length wrong");
	sample_gap_a: assert property ($rose(busy_o) |-> !ser_valid_o [*8])
		else $error("bits before sample end");
	busy_end_a: assert property ($rose(busy_o) |-> ##[1:600] !busy_o)
		else $error("readout never ends");
	valid_stands_a: assert property (ser_valid_o && !ser_ready_i |=> ser_valid_o)
		else $error("valid dropped in stall");
	data_stands_a: assert property (ser_valid_o && !ser_ready_i |=> $stable(ser_data_o))
		else $error("data moved in stall");
	word_len_a: assert property (pops_q <= 8)
		else $error("word longer than eight");
	last_end_a: assert property ($rose(ser_last_o) |-> busy_o ##1 !busy_o)
		else $error("last flag not at word end");
	cover property ($rose(busy_o));
	cover property (ser_valid_o && !ser_ready_i);
	cover property ($fell(hold_o));
endmodule

// ==== tb/beacon_rx_model.sv ====
// telemetry beacon model collecting serial readout bits
`timescale 1ns/1ps
module beacon_rx_model
(
	input  wire       core_clk_i,
	input  wire       reset_n_i,
	input  wire       stall_i,
	input  wire       clr_i,
	input  wire       ser_valid_i,
	input  wire       ser_data_i,
	output wire       ser_ready_o,
	output reg  [7:0] word_o,
	output reg  [7:0] bits_o
);
	// stall is a bench level so the slow case is exact
	assign ser_ready_o = !stall_i;
	// first bit ends on top, marker in bit 0
	always @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i || clr_i)
		begin
			word_o <= 8'h00;
			bits_o <= 8'h00;
		end
		else if (ser_valid_i && ser_ready_o)
		begin
			word_o <= {word_o[6:0], ser_data_i};
			bits_o <= bits_o + 8'h01;
		end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the sun-angle serial readout
`timescale 1ns/1ps
`include "sun_angle_regs.vh"
module tb;
	reg        core_clk_i    = 1'b0;
	reg        reset_n_i     = 1'b0;
	reg        trig_eye_i    = 1'b0;
	reg  [6:0] angle_above_i = 7'h00;
	reg        stall         = 1'b0;
	reg        clr           = 1'b0;
	wire       ser_valid_o;
	wire       ser_ready;
	wire       ser_data_o;
	wire       busy_o;
	wire       hold_o;
	wire [7:0] word;
	wire [7:0] bits;
	int        num_errors = 0;
	int        cmp_count  = 0;
	int        i;
	reg  [7:0] prev_q;
	// gray input beside expected word, marker last
	reg [15:0] rows [0:7] = '{16'h0001, 16'h0103, 16'h3F7F, 16'h60C1,
		16'h7EFD, 16'h7FFF, 16'h4183, 16'h4081};

	always #5 core_clk_i = ~core_clk_i;

	sun_angle_gray_serial_readout #(.HOLD_CYCLES(20), .SAMPLE_CYCLES(10),
		.SHIFT_DIV(4), .CHOP_HALF(3)) uut (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .clk_en_i(1'b1), .trig_eye_i(trig_eye_i),
		.angle_above_i(angle_above_i), .ser_valid_o(ser_valid_o),
		.ser_ready_i(ser_ready), .ser_data_o(ser_data_o), .ser_last_o(),
		.busy_o(busy_o), .hold_o(hold_o));

	beacon_rx_model rx (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.stall_i(stall), .clr_i(clr), .ser_valid_i(ser_valid_o),
		.ser_data_i(ser_data_o), .ser_ready_o(ser_ready), .word_o(word),
		.bits_o(bits));

	task check(input [7:0] got, input [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task results;
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// light the trigger cell long enough to charge, then darken
	task pulse;
		trig_eye_i = 1'b1;
		repeat (60) @(posedge core_clk_i);
		#1 trig_eye_i = 1'b0;
	endtask

	// one readout; a stall holds ready low while a retrigger comes
	task automatic readout(input [6:0] gray, input int stall_cyc);
		int n;
		n = 0;
		angle_above_i = gray;
		clr = 1'b1;
		stall = (stall_cyc > 0);
		@(posedge core_clk_i);
		#1 clr = 1'b0;
		pulse();
		while (busy_o !== 1'b1 && n < 300)
		begin
			@(posedge core_clk_i);
			n++;
		end
		#1;
		if (stall_cyc > 0)
		begin
			pulse(); // extra trigger in mid-word
			repeat (stall_cyc) @(posedge core_clk_i);
			#1 stall = 1'b0;
		end
		n = 0;
		while (busy_o !== 1'b0 && n < 600)
		begin
			@(posedge core_clk_i);
			n++;
		end
		repeat (20) @(posedge core_clk_i);
		#1;
	endtask

	// watchdog well past the expected run length
	initial
	begin
		#200000;
		num_errors++;
		results();
	end

	initial
	begin
		repeat (12) @(posedge core_clk_i);
		#1 reset_n_i = 1'b1;
		check({7'h00, hold_o}, 8'h01);
		repeat (30) @(posedge core_clk_i);
		#1 check({6'h00, busy_o, hold_o}, 8'h00);
		for (i = 0; i < 8; i++)
		begin
			readout(rows[i][14:8], 0);
			check(word, rows[i][7:0]);
			check(bits, 8'h08);
			if (i == 1 || i == 5 || i == 7)
				check(8'($countones(word ^ prev_q)), 8'h01);
			prev_q = word;
		end
		// stalled receiver fills the buffer; no bit may be lost
		readout(7'h55, 150);
		check(word, 8'hAB);
		check(bits, 8'h08);
		repeat (100) @(posedge core_clk_i);
		#1 check({bits[6:0], busy_o}, 8'h10);
		// reset right after the word's eighth shift, then a clean readout
		angle_above_i = 7'h2A;
		pulse();
		repeat (60) @(posedge core_clk_i);
		#1 reset_n_i = 1'b0;
		#1 check({5'h00, ser_valid_o, busy_o, hold_o}, 8'h01);
		@(posedge core_clk_i);
		#1 reset_n_i = 1'b1;
		repeat (30) @(posedge core_clk_i);
		#1 readout(7'h40, 0);
		check(word, 8'h81);
		check(bits, 8'h08);
		results();
	end
endmodule

bind sun_angle_gray_serial_readout sun_angle_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
	.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
	.trig_eye_i(trig_eye_i), .angle_above_i(angle_above_i), .ser_valid_o(ser_valid_o),
	.ser_ready_i(ser_ready_i), .ser_data_o(ser_data_o), .ser_last_o(ser_last_o),
	.busy_o(busy_o), .hold_o(hold_o));
